/* File: hdl/gsc_bank.v */
// Bank of eight gated 32-bit scalers with run line control and snapshot
// Functional notes
// - Eight 32-bit synchronous counters, six up-only and two up/down, one clock
// - Per-counter selectable input polarity inversion
// - Counter mode edges or timer every clock
// - Only counters one and two drive carry
// - Carry output high one clock after value reaches all ones, while it stays there
// - Carry chaining forms 64 or 96 bits
// - Up/down on counters three, four replaces gate
// - Preset terminal value pulls run line low
// - Individual and common gate selectable per counter
// - Load input resets enabled counters to start
// - Each counter holds writable start value
// - Per-counter run line qualification of counting
// - Read copies all counters same cycle
// - Watched run line low halts measurement
`timescale 1ns/10ps
`default_nettype none
`include "gsc_consts.vh"
module gsc_bank (
  input  wire         i_clk_sys,
  input  wire         i_sys_rst,
  input  wire [7:0]   i_count,
  input  wire [7:0]   i_gate,
  input  wire         i_common_gate,
  input  wire         i_load,
  input  wire         i_go_in,
  input  wire [7:0]   i_invert,
  input  wire [7:0]   i_edge_fall,
  input  wire [7:0]   i_timer_mode,
  input  wire [7:0]   i_use_gate,
  input  wire [7:0]   i_use_common,
  input  wire [7:0]   i_use_load,
  input  wire [7:0]   i_use_go,
  input  wire [7:0]   i_preset_en,
  input  wire [1:0]   i_updown_en,
  input  wire         i_go_watch,
  input  wire         i_go_drive,
  input  wire         i_arm,
  input  wire         i_halt,
  input  wire [7:0]   i_start_wr,
  input  wire [31:0]  i_start_data,
  input  wire         i_snap_req,
  output reg  [255:0] o_snap_data,
  output reg          o_snap_valid,
  output reg  [1:0]   o_carry,
  output reg          o_running,
  output reg          o_preset_hit,
  output reg          o_go_out,
  output reg          o_go_oe_n
);
  // Two-stage synchronisers for every pin; meta stage read by nothing else
  reg  [7:0]   cnt_m_q;
  reg  [7:0]   cnt_s_q;
  reg  [7:0]   cnt_p_q;
  reg  [7:0]   gate_m_q;
  reg  [7:0]   gate_s_q;
  reg  [2:0]   misc_m_q;
  reg  [2:0]   misc_s_q;
  wire         common_s;
  wire         load_s;
  wire         go_s;
  wire [7:0]   cnt_pol;
  wire [7:0]   cnt_pol_prev;
  wire [7:0]   ev;
  wire [7:0]   ok;
  wire [7:0]   up;
  wire [7:0]   ud_on;
  wire [7:0]   term;
  wire [7:0]   carry_all;
  wire [255:0] values;
  wire         preset_d;
  wire         go_stop;
  wire         stop_any;
  reg          run_d;

  localparam [0:0] RUN_IDLE = 1'b0;
  localparam [0:0] RUN_ON   = 1'b1;

  // Edge of the polarity-corrected pin, or every clock in timer mode
  function gsc_edge_event;
    input timer;
    input fall;
    input prev;
    input now;
    begin
      if (timer) begin
        gsc_edge_event = 1'b1;
      end else if (fall) begin
        gsc_edge_event = prev & ~now;
      end else begin
        gsc_edge_event = ~prev & now;
      end
    end
  endfunction

  // A gate that is not selected never blocks; a selected one must be open
  function gsc_gate_open;
    input use_sel;
    input level;
    begin
      gsc_gate_open = ~use_sel | level;
    end
  endfunction

  // Counters without the direction option always count up
  function gsc_count_up;
    input ud;
    input dir;
    input inv;
    begin
      gsc_count_up = ~ud | (dir ^ inv);
    end
  endfunction

  assign common_s = misc_s_q[0];
  assign load_s   = misc_s_q[1];
  assign go_s     = misc_s_q[2];

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      cnt_m_q  <= 8'h00;
      cnt_s_q  <= 8'h00;
      cnt_p_q  <= 8'h00;
      gate_m_q <= 8'h00;
      gate_s_q <= 8'h00;
      misc_m_q <= 3'h0;
      misc_s_q <= 3'h0;
    end else begin
      cnt_m_q  <= i_count;
      cnt_s_q  <= cnt_m_q;
      cnt_p_q  <= cnt_s_q;
      gate_m_q <= i_gate;
      gate_s_q <= gate_m_q;
      misc_m_q <= {i_go_in, i_load, i_common_gate};
      misc_s_q <= misc_m_q;
    end
  end

  assign cnt_pol      = cnt_s_q ^ i_invert;
  assign cnt_pol_prev = cnt_p_q ^ i_invert;
  // Only counters three and four have the direction option
  assign ud_on = {4'h0, i_updown_en, 2'h0};

  genvar g;
  generate
    for (g = 0; g < `GSC_NCNT; g = g + 1) begin : g_cnt
      assign ev[g] = gsc_edge_event(i_timer_mode[g], i_edge_fall[g], cnt_pol_prev[g], cnt_pol[g]);
      // all selected gates; gate dropped in up/down
      assign ok[g] = gsc_gate_open(i_use_gate[g] & ~ud_on[g], gate_s_q[g]) &
                     gsc_gate_open(i_use_common[g], common_s) &
                     gsc_gate_open(i_use_go[g], go_s);
      assign up[g] = gsc_count_up(ud_on[g], gate_s_q[g], i_invert[g]);
      assign term[g] = (values[32*g +: 32] == `GSC_ONES);
      gsc_counter u_cnt (
        .i_clk_sys    (i_clk_sys),
        .i_sys_rst    (i_sys_rst),
        .i_count      (ev[g] & ok[g]),
        .i_up         (up[g]),
        .i_hold_term  (i_preset_en[g]),
        .i_load       (load_s & i_use_load[g]),
        .i_start_wr   (i_start_wr[g]),
        .i_start_data (i_start_data),
        .o_value      (values[32*g +: 32]),
        .o_carry      (carry_all[g])
      );
    end
  endgenerate

  assign preset_d = |(term & i_preset_en);
  assign go_stop  = i_go_watch & ~go_s;
  // Any stop source wins over a simultaneous arm
  assign stop_any = i_halt | preset_d | go_stop;

  // With watch and drive both on, a halted bank holds the line low and so
  // blocks its own arm; turn drive on together with the arm
  always @* begin
    run_d = o_running;
    case (o_running)
      RUN_IDLE: begin
        if (i_arm && !stop_any) begin
          run_d = RUN_ON;
        end
      end
      RUN_ON: begin
        if (stop_any) begin
          run_d = RUN_IDLE;
        end
      end
      default: begin
        run_d = RUN_IDLE;
      end
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_snap_data  <= 256'h0;
      o_snap_valid <= 1'b0;
      o_carry      <= 2'h0;
      o_running    <= 1'b0;
      o_preset_hit <= 1'b0;
      o_go_out     <= 1'b0;
      o_go_oe_n    <= 1'b1;
    end else begin
      o_snap_valid <= i_snap_req;
      if (i_snap_req) begin
        o_snap_data <= values;
      end
      // carry on first two; chaining via these pins
      o_carry <= carry_all[1:0];
      o_preset_hit <= preset_d;
      o_running <= run_d;
      o_go_out  <= 1'b0;
      o_go_oe_n <= ~(i_go_drive & ~run_d);
    end
  end
endmodule
`default_nettype wire

/* File: hdl/gsc_consts.vh */
// Constants for the gated scaler counter bank
`ifndef GSC_CONSTS_VH
`define GSC_CONSTS_VH
`define GSC_NCNT        8
`define GSC_WIDTH       32
`define GSC_ONES        32'hffffffff
`define GSC_VAL_RST     32'h00000000
`define GSC_START_RST   32'h00000000
`define GSC_NCARRY      2
`define GSC_UD_FIRST    2
`define GSC_NUD         2
`endif

/* File: hdl/gsc_counter.v */
// One 32-bit up/down scaler with start value, load and carry
`timescale 1ns/10ps
`default_nettype none
`include "gsc_consts.vh"
module gsc_counter (
  input  wire        i_clk_sys,
  input  wire        i_sys_rst,
  input  wire        i_count,
  input  wire        i_up,
  input  wire        i_hold_term,
  input  wire        i_load,
  input  wire        i_start_wr,
  input  wire [31:0] i_start_data,
  output reg  [31:0] o_value,
  output reg         o_carry
);
  reg  [31:0] start_q;
  reg  [31:0] value_d;
  wire        at_term;

  assign at_term = (o_value == `GSC_ONES);

  always @* begin
    value_d = o_value;
    if (i_load) begin
      value_d = start_q;
    end else if (i_count && !(i_hold_term && at_term && i_up)) begin
      if (i_up) begin
        value_d = o_value + 32'h00000001;
      end else begin
        value_d = o_value - 32'h00000001;
      end
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      start_q <= `GSC_START_RST;
      o_value <= `GSC_VAL_RST;
      o_carry <= 1'b0;
    end else begin
      if (i_start_wr) begin
        start_q <= i_start_data;
      end
      o_value <= value_d;
      o_carry <= (value_d == `GSC_ONES);
    end
  end
endmodule
`default_nettype wire

/* File: verification/gsc_bank_asserts.sv */
// Port assertions for the scaler counter bank
`timescale 1ns/10ps
`default_nettype none
module gsc_bank_asserts (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_arm,
  input wire logic i_halt,
  input wire logic i_go_drive,
  input wire logic i_snap_req,
  input wire logic o_snap_valid,
  input wire logic o_running,
  input wire logic o_preset_hit,
  input wire logic o_go_out,
  input wire logic o_go_oe_n
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  a_snap_answer: assert property (i_snap_req |=> o_snap_valid) else $error("no snapshot");
  a_snap_cause: assert property (o_snap_valid |-> $past(i_snap_req)) else $error("stray snapshot");
  a_halt_stop: assert property (i_halt |=> !o_running) else $error("halt ignored");
  a_run_cause: assert property ($rose(o_running) |-> $past(i_arm)) else $error("run without arm");
  a_preset_halt: assert property ($rose(o_preset_hit) |-> ##[0:1] !o_running) else $error("preset no halt");
  a_halt_drive: assert property (i_halt && i_go_drive |=> !o_go_oe_n) else $error("line released");
  a_oe_follow: assert property (!$past(i_sys_rst) |-> o_go_oe_n == !($past(i_go_drive) && !o_running))
    else $error("line drive wrong");
  a_go_low: assert property (o_go_out == 1'b0) else $error("line driven high");
  cover property ($rose(o_preset_hit));
  cover property (o_snap_valid && o_running);
  cover property ($fell(o_running));
endmodule
`default_nettype wire

/* File: verification/gsc_bank_tb_top.sv */
// Self-checking bench for the scaler counter bank
`timescale 1ns/10ps
`default_nettype none
module gsc_bank_tb_top;
  logic clk = 1'b0, i_sys_rst = 1'b1, i_common_gate = 1'b0, i_load = 1'b0, i_go_watch = 1'b0;
  logic i_go_drive = 1'b0, i_arm = 1'b0, i_halt = 1'b0, i_snap_req = 1'b0, pgo = 1'b0, pin, ext_low = 1'b0;
  logic o_snap_valid, o_running, o_preset_hit, o_go_out, o_go_oe_n;
  logic [7:0] i_gate = '1, i_invert = '0, i_edge_fall = '0, i_timer_mode = '0, i_use_gate = '0;
  logic [7:0] i_use_common = '0, i_use_load = '0, i_use_go = '0, i_preset_en = '0, i_start_wr = '0;
  logic [1:0] i_updown_en = '0, o_carry;
  logic [31:0] i_start_data = '0, lf = 32'h7194, exp [8];
  logic [255:0] o_snap_data;
  wire [7:0] i_count = {8{pin}};
  // Open-drain run line with pull-up: low if the bank or another device pulls it
  wire i_go_in = o_go_oe_n & ~ext_low;
  int fails = 0, tests_run = 0;
  gsc_bank gsc_bank_i (.i_clk_sys(clk), .*);
  gsc_pulse_src gsc_pulse_src_i (.i_clk(clk), .i_n(8'h05), .i_go(pgo), .o_pin(pin));
  initial forever #25 clk = ~clk;
  // Run takes about 78 cycles; the limit allows about fifteen times that
  initial #60us complete_run(1);
  task complete_run(input int late);
    fails += late;
    $display("%0d checks, %0d mismatches", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) $display("wrong value at %0t: %h not %h", $time, g, e);
    if (g !== e) fails++;
  endtask
  task snap;
    @(posedge clk) i_snap_req <= 1'b1;
    @(posedge clk) i_snap_req <= 1'b0;
    @(negedge clk) cmp(o_snap_valid, 1'b1); // answer next cycle
    for (int k = 0; k < 8; k++) cmp(o_snap_data[32*k+:32], exp[k]); // coherent copy
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  initial begin
    repeat (4) @(posedge clk);
    i_sys_rst <= 1'b0;
    lf = nxt(lf);
    @(posedge clk) i_start_data <= lf;
    i_start_wr <= 8'hfe;
    @(posedge clk) i_start_data <= 32'hfffffffa; // ones minus five
    i_start_wr <= 8'h01;
    @(posedge clk) i_start_wr <= 8'h00;
    i_use_load <= 8'h7f;
    i_load <= 1'b1;
    repeat (3) @(posedge clk);
    i_load <= 1'b0;
    exp = '{32'hfffffffa, lf, lf, lf, lf, lf, lf, 32'h00000000};
    repeat (4) @(posedge clk);
    snap; // load reaches enabled counters only
    @(posedge clk) i_invert <= 8'h0a;
    i_edge_fall <= 8'h06;
    i_updown_en <= 2'b01;
    i_gate <= 8'h7b;
    i_use_gate <= 8'h80;
    i_preset_en <= 8'h01;
    i_go_drive <= 1'b1;
    i_arm <= 1'b1;
    @(posedge clk) i_arm <= 1'b0;
    @(negedge clk) cmp(o_running, 1'b1); // armed
    @(posedge clk) pgo <= 1'b1;
    @(posedge clk) pgo <= 1'b0;
    repeat (26) @(posedge clk);
    for (int k = 1; k < 7; k++) exp[k] = k == 2 ? lf - 5 : lf + 5;
    exp[0] = '1;
    @(negedge clk) cmp({o_running, o_go_oe_n, o_carry}, 4'h1); // preset halt pulls line
    snap; // edges, direction, gate, no wrap
    @(posedge clk) i_preset_en <= 8'h00;
    i_go_drive <= 1'b0;
    i_go_watch <= 1'b1;
    repeat (4) @(posedge clk);
    i_arm <= 1'b1;
    @(posedge clk) i_arm <= 1'b0;
    @(negedge clk) cmp(o_running, 1'b1); // high line lets run start
    @(posedge clk) i_timer_mode <= 8'h61;
    i_use_common <= 8'h20;
    repeat (10) @(posedge clk);
    i_timer_mode <= 8'h00;
    exp[0] = 32'h00000009;
    exp[6] = lf + 15;
    snap; // timer, closed common gate, wrap
    cmp(o_carry, 2'h0); // carry low after wrap
    @(posedge clk) ext_low <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk) cmp(o_running, 1'b1); // line through synchroniser, o_running updates next edge
    @(negedge clk) cmp(o_running, 1'b0); // watched line low halts
    @(posedge clk) ext_low <= 1'b0;
    repeat (3) @(posedge clk);
    i_arm <= 1'b1;
    i_go_drive <= 1'b1;
    @(posedge clk) i_arm <= 1'b0;
    @(negedge clk) cmp({o_running, o_go_oe_n}, 2'h3); // armed, line released
    @(posedge clk) i_halt <= 1'b1;
    @(posedge clk) i_halt <= 1'b0;
    @(negedge clk) cmp({o_running, o_go_oe_n}, 2'h0); // halt pulls line low
    complete_run(0);
  end
endmodule
bind gsc_bank gsc_bank_asserts gsc_bank_asserts_i (.*);
`default_nettype wire

/* File: verification/gsc_pulse_src.sv */
// Stand-in pulse source for the external count pins
`timescale 1ns/10ps
`default_nettype none
module gsc_pulse_src (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_n,
  input  wire logic       i_go,
  output var  logic       o_pin
);
  int left = 0;
  // Each level stands two clocks so no edge is lost in the synchronisers
  always @(posedge i_clk) begin
    if (i_go && left == 0) left <= 4 * i_n;
    else if (left != 0) left <= left - 1;
  end
  // Idle low, as the pins are terminated to ground
  always @* o_pin = left[1];
endmodule
`default_nettype wire
